/* File: shared/dma_pkg.sv */
package dma_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_SRC = 8'h0c;
  localparam logic [7:0] OFS_SRC_INC = 8'h10;
  localparam logic [7:0] OFS_COUNT = 8'h14;
  localparam logic [7:0] OFS_DST = 8'h18;
  localparam logic [7:0] OFS_DST_INC = 8'h1c;
  localparam logic [7:0] OFS_FILL_LO = 8'h20;
  localparam logic [7:0] OFS_FILL_HI = 8'h24;

  // control field positions
  localparam int CTL_START = 0;
  localparam int CTL_EXT = 1;
  localparam int CTL_SNG = 2;
  localparam int CTL_DIR = 3;
  localparam int CTL_SIZE = 4;
  localparam int CTL_MODE = 7;
  localparam int CTL_DELAY = 8;

  // status field positions
  localparam int ST_CFG_ERR = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ACTIVE = 8;
  localparam int EVENT_W = 2;

  // transfer setting size codes
  localparam logic [2:0] SZ_1B = 3'h0;
  localparam logic [2:0] SZ_2B = 3'h1;
  localparam logic [2:0] SZ_4B = 3'h2;
  localparam logic [2:0] SZ_8B = 3'h3;
  localparam logic [2:0] SZ_4DW = 3'h4;
  localparam logic [2:0] SZ_8DW = 3'h5;
  localparam logic [2:0] SZ_16DW = 3'h6;
  localparam logic [2:0] SZ_32DW = 3'h7;

  // burst geometry
  localparam logic [5:0] BOUNDARY_DW = 6'h20;
  localparam logic [31:0] BEAT_BYTES = 32'h0000_0008;
  localparam logic [31:0] INC_POS8 = 32'h0000_0008;
  localparam logic [31:0] INC_NEG8 = 32'hffff_fff8;

  // reset values
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [63:0] FILL_RESET = 64'h0000_0000_0000_0000;
  localparam logic [EVENT_W-1:0] EVENT_RESET = 2'h0;

  typedef struct packed {
    logic ext_sel;
    logic single;
    logic dir;
    logic [2:0] size;
    logic mode;
    logic [7:0] delay;
  } ctrl_s;

  localparam ctrl_s CTRL_RESET = ctrl_s'(15'h0000);

  typedef struct packed {
    logic valid;
    logic write;
    logic flyby;
    logic lock;
    logic [1:0] size;
    logic [5:0] beats;
    logic [31:0] addr;
    logic [63:0] wdata;
  } bus_req_s;

  typedef struct packed {
    logic ack;
    logic [63:0] rdata;
  } bus_rsp_s;

  function automatic logic [2:0] size_mask(input logic [2:0] size);
    case (size)
      SZ_1B: size_mask = 3'h0;
      SZ_2B: size_mask = 3'h1;
      SZ_4B: size_mask = 3'h3;
      default: size_mask = 3'h7;
    endcase
  endfunction

  function automatic logic [31:0] unit_bytes(input logic [2:0] size);
    case (size)
      SZ_1B: unit_bytes = 32'h0000_0001;
      SZ_2B: unit_bytes = 32'h0000_0002;
      SZ_4B: unit_bytes = 32'h0000_0004;
      default: unit_bytes = BEAT_BYTES;
    endcase
  endfunction

  function automatic logic [5:0] burst_dw(input logic [2:0] size);
    case (size)
      SZ_4DW: burst_dw = 6'h04;
      SZ_8DW: burst_dw = 6'h08;
      SZ_16DW: burst_dw = 6'h10;
      default: burst_dw = 6'h20;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

endpackage

/* File: hw/cfg_check.sv */
`timescale 1ns/1ps
module cfg_check (
  // channel settings
  input wire dma_pkg::ctrl_s ctrl,
  input wire logic [31:0] src,
  input wire logic [31:0] src_inc,
  input wire logic [31:0] count,
  input wire logic [31:0] dst,
  input wire logic [31:0] dst_inc,
  // verdict
  output logic error
);

  logic [2:0] m;
  logic [2:0] src_exp;
  logic [2:0] dst_exp;
  logic burst;

  always_comb begin
    m = dma_pkg::size_mask(ctrl.size);
    burst = ctrl.size[2];
    src_exp = (src_inc[31] && ctrl.size >= dma_pkg::SZ_8B) ? 3'h7 : 3'h0;
    dst_exp = dst_inc[31] ? m : 3'h0;
    error = 1'b0;
    if (ctrl.single) begin
      if (!ctrl.ext_sel && ctrl.dir) begin
        error = 1'b1;
      end
      if ((src[2:0] & m) != src_exp || (count[2:0] & m) != 3'h0) begin
        error = 1'b1;
      end
      if (burst) begin
        if (src_inc != dma_pkg::INC_POS8 && src_inc != dma_pkg::INC_NEG8 &&
            src_inc != dma_pkg::WORD_RESET) begin
          error = 1'b1;
        end
      end else if ((src_inc[2:0] & m) != 3'h0) begin
        error = 1'b1;
      end
      if (src_inc == dma_pkg::WORD_RESET && !ctrl.dir) begin
        error = 1'b1;
      end
    end else begin
      if (ctrl.size >= dma_pkg::SZ_16DW) begin
        error = 1'b1;
      end
      if ((src[2:0] & m) != src_exp || (dst[2:0] & m) != dst_exp ||
          (src_inc[2:0] & m) != 3'h0 || (dst_inc[2:0] & m) != 3'h0 ||
          (count[2:0] & m) != 3'h0) begin
        error = 1'b1;
      end
    end
  end

endmodule // cfg_check

/* File: hw/burst_split.sv */
`timescale 1ns/1ps
module burst_split (
  // position and settings
  input wire logic [4:0] idx,
  input wire logic neg,
  input wire logic mode,
  input wire logic [2:0] size,
  input wire logic [5:0] left,
  input wire logic [5:0] remain,
  // piece
  output logic [5:0] start_left,
  output logic [5:0] piece,
  output logic lock
);

  logic [5:0] n;
  logic [5:0] off;
  logic [5:0] to_bound;

  always_comb begin
    n = dma_pkg::burst_dw(size);
    off = {1'b0, idx} & (n - 6'h01);
    if (mode) begin
      start_left = n;
    end else if (neg) begin
      start_left = off + 6'h01;
    end else begin
      start_left = n - off;
    end
    to_bound = neg ? ({1'b0, idx} + 6'h01) : (dma_pkg::BOUNDARY_DW - {1'b0, idx});
    piece = left;
    if (to_bound < piece) begin
      piece = to_bound;
    end
    if (remain < piece) begin
      piece = remain;
    end
    lock = (piece < left) && (piece < remain);
  end

endmodule // burst_split

/* File: hw/dma_channel.sv */
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
module dma_channel (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register bus
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // internal system bus
  output dma_pkg::bus_req_s bus_req,
  input wire dma_pkg::bus_rsp_s bus_rsp,
  // interrupt
  output logic irq
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CHECK,
    ST_GAP,
    ST_LOAD,
    ST_MOVE,
    ST_READ,
    ST_WRITE
  } state_e;

  state_e state;
  state_e next_state;
  dma_pkg::ctrl_s ctrl;
  dma_pkg::ctrl_s next_ctrl;
  logic [31:0] src;
  logic [31:0] next_src;
  logic [31:0] src_inc;
  logic [31:0] next_src_inc;
  logic [31:0] count;
  logic [31:0] next_count;
  logic [31:0] dst;
  logic [31:0] next_dst;
  logic [31:0] dst_inc;
  logic [31:0] next_dst_inc;
  logic [63:0] fill;
  logic [63:0] next_fill;
  logic [63:0] hold;
  logic [63:0] next_hold;
  logic [dma_pkg::EVENT_W-1:0] status;
  logic [dma_pkg::EVENT_W-1:0] next_status;
  logic [dma_pkg::EVENT_W-1:0] mask;
  logic [dma_pkg::EVENT_W-1:0] next_mask;
  logic [7:0] delay_cnt;
  logic [7:0] next_delay_cnt;
  logic [5:0] beats;
  logic [5:0] next_beats;
  logic [5:0] left;
  logic [5:0] next_left;
  logic lock_q;
  logic next_lock_q;
  logic resp;
  logic next_resp;
  logic [31:0] next_readdata;

  logic active;
  logic burst;
  logic cfg_error;
  logic [31:0] src_addr;
  logic [31:0] dst_addr;
  logic [31:0] unit;
  logic [31:0] step;
  logic [31:0] count_after;
  logic [5:0] remain;
  logic [5:0] start_left;
  logic [5:0] eff_left;
  logic [5:0] piece;
  logic piece_lock;
  logic [31:0] ctrl_word;
  logic [31:0] status_word;

  always_comb begin
    active = state != ST_IDLE;
    burst = ctrl.single && ctrl.size[2];
    src_addr = src_inc[31] ? (src ^ {29'h0000_0000, dma_pkg::size_mask(ctrl.size)}) : src;
    dst_addr = dst_inc[31] ? (dst ^ {29'h0000_0000, dma_pkg::size_mask(ctrl.size)}) : dst;
    unit = burst ? dma_pkg::BEAT_BYTES : dma_pkg::unit_bytes(ctrl.size);
    step = src_inc;
    count_after = count - unit;
    remain = (count[31:3] > 32'h0000_0020) ? dma_pkg::BOUNDARY_DW : count[8:3];
    eff_left = (left == 6'h00) ? start_left : left;
    ctrl_word = {16'h0000, ctrl.delay, ctrl.mode, ctrl.size, ctrl.dir, ctrl.single,
                 ctrl.ext_sel, active};
    status_word = {23'h00_0000, active, 6'h00, status};
  end

  cfg_check u_cfg_check (
    .ctrl(ctrl),
    .src(src),
    .src_inc(src_inc),
    .count(count),
    .dst(dst),
    .dst_inc(dst_inc),
    .error(cfg_error)
  );

  burst_split u_burst_split (
    .idx(src_addr[7:3]),
    .neg(src_inc[31]),
    .mode(ctrl.mode),
    .size(ctrl.size),
    .left(eff_left),
    .remain(remain),
    .start_left(start_left),
    .piece(piece),
    .lock(piece_lock)
  );

  // register bus slave: one wait state on every access
  always_comb begin
    next_resp = (read || write) && !resp;
    waitrequest = (read || write) && !resp;
    next_readdata = readdata;
    if (read && !resp) begin
      case (address)
        dma_pkg::OFS_CONTROL: next_readdata = ctrl_word;
        dma_pkg::OFS_STATUS: next_readdata = status_word;
        dma_pkg::OFS_MASK: next_readdata = {30'h0000_0000, mask};
        dma_pkg::OFS_SRC: next_readdata = src;
        dma_pkg::OFS_SRC_INC: next_readdata = src_inc;
        dma_pkg::OFS_COUNT: next_readdata = count;
        dma_pkg::OFS_DST: next_readdata = dst;
        dma_pkg::OFS_DST_INC: next_readdata = dst_inc;
        dma_pkg::OFS_FILL_LO: next_readdata = fill[31:0];
        dma_pkg::OFS_FILL_HI: next_readdata = fill[63:32];
        default: next_readdata = dma_pkg::WORD_RESET;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      resp <= 1'b0;
      readdata <= 32'h0000_0000;
    end else begin
      resp <= next_resp;
      readdata <= next_readdata;
    end
  end

  // registers and transfer engine
  always_comb begin
    logic wr;
    logic [31:0] merged;
    logic [dma_pkg::EVENT_W-1:0] events;
    logic [dma_pkg::EVENT_W-1:0] clr;
    wr = write && resp;
    merged = dma_pkg::WORD_RESET;
    events = dma_pkg::EVENT_RESET;
    clr = dma_pkg::EVENT_RESET;
    next_state = state;
    next_ctrl = ctrl;
    next_src = src;
    next_src_inc = src_inc;
    next_count = count;
    next_dst = dst;
    next_dst_inc = dst_inc;
    next_fill = fill;
    next_hold = hold;
    next_mask = mask;
    next_delay_cnt = delay_cnt;
    next_beats = beats;
    next_left = left;
    next_lock_q = lock_q;
    bus_req = '0;
    bus_req.size = (ctrl.size >= dma_pkg::SZ_8B) ? 2'h3 : ctrl.size[1:0];
    bus_req.wdata = fill;
    if (wr) begin
      case (address)
        dma_pkg::OFS_CONTROL: begin
          merged = dma_pkg::merge(ctrl_word, writedata, byteenable);
          if (!active) begin
            next_ctrl.ext_sel = merged[dma_pkg::CTL_EXT];
            next_ctrl.single = merged[dma_pkg::CTL_SNG];
            next_ctrl.dir = merged[dma_pkg::CTL_DIR];
            next_ctrl.size = merged[dma_pkg::CTL_SIZE +: 3];
            next_ctrl.mode = merged[dma_pkg::CTL_MODE];
            next_ctrl.delay = merged[dma_pkg::CTL_DELAY +: 8];
            if (byteenable[0] && writedata[dma_pkg::CTL_START]) begin
              next_state = ST_CHECK;
            end
          end
        end
        dma_pkg::OFS_STATUS: begin
          if (byteenable[0]) begin
            clr = writedata[dma_pkg::EVENT_W-1:0];
          end
        end
        dma_pkg::OFS_MASK: begin
          merged = dma_pkg::merge({30'h0000_0000, mask}, writedata, byteenable);
          next_mask = merged[dma_pkg::EVENT_W-1:0];
        end
        dma_pkg::OFS_SRC: if (!active) next_src = dma_pkg::merge(src, writedata, byteenable);
        dma_pkg::OFS_SRC_INC: begin
          if (!active) next_src_inc = dma_pkg::merge(src_inc, writedata, byteenable);
        end
        dma_pkg::OFS_COUNT: begin
          if (!active) next_count = dma_pkg::merge(count, writedata, byteenable);
        end
        dma_pkg::OFS_DST: if (!active) next_dst = dma_pkg::merge(dst, writedata, byteenable);
        dma_pkg::OFS_DST_INC: begin
          if (!active) next_dst_inc = dma_pkg::merge(dst_inc, writedata, byteenable);
        end
        dma_pkg::OFS_FILL_LO: next_fill[31:0] = dma_pkg::merge(fill[31:0], writedata, byteenable);
        dma_pkg::OFS_FILL_HI: begin
          next_fill[63:32] = dma_pkg::merge(fill[63:32], writedata, byteenable);
        end
        default: begin
        end
      endcase
    end
    case (state)
      ST_IDLE: begin
      end
      ST_CHECK: begin
        next_left = 6'h00;
        if (cfg_error) begin
          events[dma_pkg::ST_CFG_ERR] = 1'b1;
          next_state = ST_IDLE;
        end else if (count == dma_pkg::WORD_RESET) begin
          events[dma_pkg::ST_DONE] = 1'b1;
          next_state = ST_IDLE;
        end else begin
          next_state = ST_LOAD;
        end
      end
      ST_GAP: begin
        if (delay_cnt == 8'h00) begin
          next_state = ST_LOAD;
        end else begin
          next_delay_cnt = delay_cnt - 8'h01;
        end
      end
      ST_LOAD: begin
        next_beats = burst ? piece : 6'h01;
        next_lock_q = burst && piece_lock;
        next_left = burst ? eff_left : 6'h00;
        next_state = ctrl.single ? ST_MOVE : ST_READ;
      end
      ST_MOVE: begin
        bus_req.valid = 1'b1;
        bus_req.write = !ctrl.dir;
        bus_req.flyby = ctrl.ext_sel;
        bus_req.lock = lock_q;
        bus_req.beats = beats;
        bus_req.addr = src_addr;
        if (bus_rsp.ack) begin
          next_src = src + step;
          next_count = count_after;
          next_beats = beats - 6'h01;
          if (burst) begin
            next_left = left - 6'h01;
          end
          if (count_after == dma_pkg::WORD_RESET) begin
            events[dma_pkg::ST_DONE] = 1'b1;
            next_state = ST_IDLE;
          end else if (beats == 6'h01) begin
            next_delay_cnt = ctrl.delay;
            next_state = lock_q ? ST_LOAD : ST_GAP;
          end
        end
      end
      ST_READ: begin
        bus_req.valid = 1'b1;
        bus_req.beats = 6'h01;
        bus_req.addr = src_addr;
        if (bus_rsp.ack) begin
          next_hold = bus_rsp.rdata;
          next_state = ST_WRITE;
        end
      end
      ST_WRITE: begin
        bus_req.valid = 1'b1;
        bus_req.write = 1'b1;
        bus_req.beats = 6'h01;
        bus_req.addr = dst_addr;
        bus_req.wdata = hold;
        if (bus_rsp.ack) begin
          next_src = src + step;
          next_dst = dst + dst_inc;
          next_count = count_after;
          if (count_after == dma_pkg::WORD_RESET) begin
            events[dma_pkg::ST_DONE] = 1'b1;
            next_state = ST_IDLE;
          end else begin
            next_delay_cnt = ctrl.delay;
            next_state = ST_GAP;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
    next_status = (status & ~clr) | events;
    irq = |(status & mask);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      ctrl <= dma_pkg::CTRL_RESET;
      src <= dma_pkg::WORD_RESET;
      src_inc <= dma_pkg::WORD_RESET;
      count <= dma_pkg::WORD_RESET;
      dst <= dma_pkg::WORD_RESET;
      dst_inc <= dma_pkg::WORD_RESET;
      fill <= dma_pkg::FILL_RESET;
      hold <= dma_pkg::FILL_RESET;
      status <= dma_pkg::EVENT_RESET;
      mask <= dma_pkg::EVENT_RESET;
      delay_cnt <= 8'h00;
      beats <= 6'h00;
      left <= 6'h00;
      lock_q <= 1'b0;
    end else begin
      state <= next_state;
      ctrl <= next_ctrl;
      src <= next_src;
      src_inc <= next_src_inc;
      count <= next_count;
      dst <= next_dst;
      dst_inc <= next_dst_inc;
      fill <= next_fill;
      hold <= next_hold;
      status <= next_status;
      mask <= next_mask;
      delay_cnt <= next_delay_cnt;
      beats <= next_beats;
      left <= next_left;
      lock_q <= next_lock_q;
    end
  end

endmodule // dma_channel

/* File: tb/dma_channel_sva.sv */
`timescale 1ns/1ps
module dma_channel_sva (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register bus
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // internal bus and interrupt
  input wire dma_pkg::bus_req_s bus_req,
  input wire dma_pkg::bus_rsp_s bus_rsp,
  input wire logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic beat;
  assign beat = bus_req.valid && bus_rsp.ack;
  sequence locked_end;
    beat && bus_req.lock && bus_req.beats == 6'h01;
  endsequence
  sequence one_load;
    !bus_req.valid ##1 bus_req.valid;
  endsequence
  one_wait_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("access took more than one wait state");
  req_hold_a: assert property (bus_req.valid && !bus_rsp.ack |=> $stable(bus_req))
    else $error("bus request changed before ack");
  beat_down_a: assert property (beat && bus_req.beats > 6'h01 |=>
    bus_req.valid && bus_req.beats == $past(bus_req.beats) - 6'h01)
    else $error("beat count did not step down");
  beat_step_a: assert property (beat && bus_req.beats > 6'h01 |=>
    (bus_req.addr - $past(bus_req.addr)) inside {32'h8, 32'hffff_fff8, 32'h0})
    else $error("burst address step not 8, 0 or -8");
  burst_size_a: assert property (bus_req.valid && bus_req.beats > 6'h01 |->
    bus_req.size == 2'h3)
    else $error("burst beat not 8 bytes");
  piece_range_a: assert property (bus_req.valid |->
    bus_req.beats inside {[6'h01:6'h20]})
    else $error("piece length out of range");
  boundary_a: assert property (bus_req.valid |->
    ({2'h0, bus_req.addr[7:3]} + 7'(bus_req.beats) <= 7'h20) ||
    ({2'h0, bus_req.addr[7:3]} + 7'h01 >= 7'(bus_req.beats)))
    else $error("piece crosses 32 double word boundary");
  lock_chain_a: assert property (locked_end |=> one_load)
    else $error("locked piece not followed back to back");
  req_gap_a: assert property (beat && !bus_req.lock && bus_req.beats == 6'h01 &&
    (bus_req.write || bus_req.flyby) |=>
    !bus_req.valid [*2])
    else $error("next request too early");
endmodule // dma_channel_sva
bind dma_channel dma_channel_sva dma_channel_sva_inst (.clock(clock), .rst_n(rst_n),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
  .bus_req(bus_req), .bus_rsp(bus_rsp), .irq(irq));

/* File: tb/mem_model.sv */
`timescale 1ns/1ps
module mem_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // pace select
  input wire logic slow,
  // internal bus
  input wire dma_pkg::bus_req_s bus_req,
  output dma_pkg::bus_rsp_s bus_rsp
);
  logic [1:0] waited;
  logic [63:0] last;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      waited <= 2'h0;
      last <= 64'h0;
    end else if (bus_rsp.ack) begin
      waited <= 2'h0;
      last <= bus_rsp.rdata;
    end else if (bus_req.valid) begin
      waited <= waited + 2'h1;
    end
  end
  // data only in the ack cycle, inverted otherwise
  always_comb begin
    bus_rsp.ack = bus_req.valid && (!slow || waited == 2'h2);
    bus_rsp.rdata = bus_rsp.ack ? {bus_req.addr, ~bus_req.addr} : ~last;
  end
endmodule // mem_model

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  typedef struct {
    logic [15:0] ctl;
    logic [31:0] src, inc, cnt, dst, a0, exp_src, beats;
    logic [1:0] st;
  } case_s;
  localparam logic [63:0] FILL_VAL = 64'h0123_4567_89ab_cdef;
  logic clock = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0, slow = 1'b0;
  logic [7:0] address = 8'h0;
  logic [31:0] writedata = 32'h0, readdata, d;
  logic [3:0] byteenable = 4'h0;
  logic waitrequest, irq, fill, gap_on, seen, was_valid, was_lock, irq_en, ext_on;
  dma_pkg::bus_req_s bus_req;
  dma_pkg::bus_rsp_s bus_rsp;
  logic [31:0] exp_r, exp_w, inc, gap_exp, idle, nbeat, last_ra;
  logic [6:0] pieces[$];
  int bad_count = 0, n_compared = 0;
  case_s rows [13] = '{
    '{16'h0034, 32'h1000, 32'h8, 32'h10, 32'hdead0000, 32'h1000, 32'h1010, 2, 2'h2},
    '{16'h0034, 32'h1107, 32'hfffffff8, 32'h10, 0, 32'h1100, 32'h10f7, 2, 2'h2},
    '{16'h0204, 32'h2001, 32'h1, 32'h3, 32'hdead0000, 32'h2001, 32'h2004, 3, 2'h2},
    '{16'h0020, 32'h3000, 32'h4, 32'h8, 32'h4000, 32'h3000, 32'h3008, 4, 2'h2},
    '{16'h0130, 32'h200, 32'h8, 32'h8, 32'h300, 32'h200, 32'h208, 2, 2'h2},
    '{16'h003e, 32'h1000, 32'h0, 32'h10, 0, 32'h1000, 32'h1000, 2, 2'h2},
    '{16'h0034, 32'h1000, 32'h0, 32'h8, 0, 0, 32'h1000, 0, 2'h1},
    '{16'h0044, 32'h1000, 32'h10, 32'h8, 0, 0, 32'h1000, 0, 2'h1},
    '{16'h0014, 32'h1001, 32'h2, 32'h2, 0, 0, 32'h1001, 0, 2'h1},
    '{16'h0024, 32'h1000, 32'h4, 32'h6, 0, 0, 32'h1000, 0, 2'h1},
    '{16'h0034, 32'h1100, 32'hfffffff8, 32'h8, 0, 0, 32'h1100, 0, 2'h1},
    '{16'h0034, 32'h1000, 32'h8, 32'h0, 0, 0, 32'h1000, 0, 2'h2},
    '{16'h0036, 32'h1000, 32'h0, 32'h8, 0, 0, 32'h1000, 0, 2'h1}};
  case_s b0 = '{16'h0044, 32'h10a8, 32'h8, 32'h58, 0, 32'h10a8, 32'h1100, 11, 2'h2};
  case_s b1 = '{16'h00c4, 32'h10a8, 32'h8, 32'h60, 0, 32'h10a8, 32'h1108, 12, 2'h2};
  logic [6:0] p0 [3] = '{7'h03, 7'h04, 7'h04};
  logic [6:0] p1 [4] = '{7'h04, 7'h04, 7'h43, 7'h01};

  dma_channel dma_channel_inst (.clock(clock), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .bus_req(bus_req),
    .bus_rsp(bus_rsp), .irq(irq));
  mem_model mem_model_inst (.clock(clock), .rst_n(rst_n), .slow(slow),
    .bus_req(bus_req), .bus_rsp(bus_rsp));

  always #25 clock = ~clock;

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic bus_write(input logic [7:0] a, input logic [31:0] v,
                           input logic [3:0] be = 4'hf);
    address <= a;
    writedata <= v;
    byteenable <= be;
    write <= 1'b1;
    @(posedge clock iff !waitrequest);
    write <= 1'b0;
    @(posedge clock);
  endtask

  task automatic bus_read(input logic [7:0] a, output logic [31:0] v);
    address <= a;
    read <= 1'b1;
    @(posedge clock iff !waitrequest);
    v = readdata;
    read <= 1'b0;
    @(posedge clock);
  endtask

  // bus monitor: addresses, data, pieces and spacing
  always @(posedge clock) begin
    if (bus_req.valid && !was_valid) begin
      pieces.push_back({bus_req.lock, bus_req.beats});
      if (gap_on && seen && !was_lock) check(idle, gap_exp);
      idle = 0;
    end
    if (!bus_req.valid) idle++;
    if (bus_req.valid && bus_rsp.ack) begin
      nbeat++;
      seen = 1'b1;
      was_lock = bus_req.lock;
      check(bus_req.flyby, ext_on);
      if (!bus_req.write || fill) begin
        check(bus_req.addr, exp_r);
        exp_r += inc;
      end else begin
        check(bus_req.addr, exp_w);
        exp_w += inc;
      end
      if (!bus_req.write) last_ra = bus_req.addr;
      if (bus_req.write && bus_req.size == 2'h3)
        check(bus_req.wdata, fill ? FILL_VAL : {last_ra, ~last_ra});
    end
    was_valid = bus_req.valid;
  end

  task automatic run_case(input case_s c);
    int n;
    exp_r = c.a0;
    exp_w = c.dst;
    inc = c.inc;
    fill = c.ctl[2] && !c.ctl[1];
    gap_on = !c.ctl[1];
    ext_on = c.ctl[1];
    gap_exp = 32'(c.ctl[15:8]) + 32'h2;
    seen = 1'b0;
    nbeat = 0;
    pieces.delete();
    bus_write(dma_pkg::OFS_SRC, c.src);
    bus_write(dma_pkg::OFS_SRC_INC, c.inc);
    bus_write(dma_pkg::OFS_COUNT, c.cnt);
    bus_write(dma_pkg::OFS_DST, c.dst);
    bus_write(dma_pkg::OFS_DST_INC, c.ctl[2] ? 32'h7 : c.inc);
    bus_write(dma_pkg::OFS_CONTROL, {16'h0, c.ctl | 16'h1});
    d = 0;
    for (n = 0; n < 400 && d[1:0] == 2'h0; n++) bus_read(dma_pkg::OFS_STATUS, d);
    check(d[1:0], c.st);
    check(irq, irq_en);
    check(nbeat, c.beats);
    bus_read(dma_pkg::OFS_SRC, d);
    check(d, c.exp_src);
    bus_write(dma_pkg::OFS_STATUS, 32'h3);
    bus_read(dma_pkg::OFS_STATUS, d);
    check({d[1:0], irq}, 3'h0);
  endtask

  initial begin
    gap_on = 1'b0;
    was_valid = 1'b0;
    was_lock = 1'b0;
    idle = 0;
    nbeat = 0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    bus_write(dma_pkg::OFS_SRC, 32'hffff_ffff);
    bus_write(dma_pkg::OFS_SRC, 32'h0, 4'h2);
    bus_read(dma_pkg::OFS_SRC, d);
    check(d, 32'hffff_00ff);
    bus_write(8'h40, 32'h5);
    bus_read(8'h40, d);
    check(d, 32'h0);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 10; i++) begin
      bus_read(8'(i * 4), d);
      check(d, 32'h0);
    end
    bus_write(dma_pkg::OFS_FILL_LO, FILL_VAL[31:0]);
    bus_write(dma_pkg::OFS_FILL_HI, FILL_VAL[63:32]);
    bus_write(dma_pkg::OFS_MASK, 32'h3);
    irq_en = 1'b1;
    for (int i = 0; i < 13; i++) begin
      slow <= i[0];
      run_case(rows[i]);
    end
    bus_write(dma_pkg::OFS_MASK, 32'h0);
    irq_en = 1'b0;
    run_case(rows[6]);
    bus_write(dma_pkg::OFS_MASK, 32'h3);
    irq_en = 1'b1;
    run_case(b0);
    foreach (p0[i]) check(pieces[i], p0[i]);
    check(pieces.size(), 3);
    slow <= 1'b1;
    run_case(b1);
    foreach (p1[i]) check(pieces[i], p1[i]);
    check(pieces.size(), 4);
    final_report();
  end

  initial begin
    #2000000;
    bad_count++;
    final_report();
  end
endmodule // tb_top
